// ### hw/evsel_pkg.sv
// Purpose: constants and carriers for the cache and bus event selector
// Assumes: one core clock; bus-cycle events arrive with a bus-cycle strobe
// Notes: unit-mask qualification field positions are plain choices
package evsel_pkg;

	// ==========================================
	// event codes
	localparam logic [7:0] EV_L2_CODE_FETCH = 8'h28;
	localparam logic [7:0] EV_L2_READ = 8'h29;
	localparam logic [7:0] EV_L2_WRITE = 8'h2a;
	localparam logic [7:0] EV_L2_REQUEST = 8'h2e;
	localparam logic [7:0] EV_L2_BUSY_REFUSE = 8'h30;
	localparam logic [7:0] EV_L2_IDLE = 8'h32;
	localparam logic [7:0] EV_FREQ_TRANS = 8'h3a;
	localparam logic [7:0] EV_THERMAL_TRIP = 8'h3b;
	localparam logic [7:0] EV_RUNNING_BUS = 8'h3c;
	localparam logic [7:0] EV_L1_CACHE_READ = 8'h40;
	localparam logic [7:0] EV_L1_CACHE_WRITE = 8'h41;
	localparam logic [7:0] EV_L1_LOCKED_READ = 8'h42;
	localparam logic [7:0] EV_L1_ALL_REF = 8'h43;
	localparam logic [7:0] EV_L1_CACHE_REF = 8'h44;
	localparam logic [7:0] EV_L1_REPLACE = 8'h45;
	localparam logic [7:0] EV_L1_MOD_ALLOC = 8'h46;
	localparam logic [7:0] EV_L1_MOD_EVICT = 8'h47;
	localparam logic [7:0] EV_L1_MISS_PEND = 8'h48;
	localparam logic [7:0] EV_DTLB_MISS = 8'h49;
	localparam logic [7:0] EV_PREF_MISS = 8'h4b;
	localparam logic [7:0] EV_L1_PREFETCH_REQUEST_EVENT = 8'h4f;
	localparam logic [7:0] EV_BUS_READ_OUT = 8'h60;
	localparam logic [7:0] EV_BUS_BLOCK = 8'h61;
	localparam logic [7:0] EV_BUS_DATA_VALID = 8'h62;
	localparam logic [7:0] EV_BUS_LOCK = 8'h63;
	localparam logic [7:0] EV_BUS_DATA_RCV = 8'h64;
	localparam logic [7:0] EV_BUS_BURST_READ = 8'h65;

	// ==========================================
	// fixed unit masks
	localparam logic [7:0] UM_ZERO = 8'h00;
	localparam logic [7:0] UM_RUNNING = 8'h01;
	localparam logic [7:0] UM_SERIAL = 8'h02;
	localparam logic [7:0] UM_ALL_REF = 8'h01;
	localparam logic [7:0] UM_CACHE_REF = 8'h02;
	localparam logic [7:0] UM_REPLACE = 8'h0f;
	localparam logic [7:0] UM_NT_PREF = 8'h00;
	localparam logic [7:0] UM_L1_HINT = 8'h01;
	localparam logic [7:0] UM_L2_HINT = 8'h02;
	localparam logic [7:0] UM_STREAM = 8'h03;
	localparam logic [7:0] UM_DATA_RCV = 8'h40;
	localparam logic [7:0] UM_FREQ_ANY = 8'h00;
	localparam logic [7:0] UM_FREQ_ONLY = 8'h10;
	localparam logic [7:0] UM_THERMAL = 8'hc0;

	// ==========================================
	// unit-mask qualification fields
	localparam int STATE_LSB = 0;
	localparam int STATE_W = 4;
	localparam int PREF_INC_BIT = 4;
	localparam int PREF_EXC_BIT = 5;
	localparam int SEL_LSB = 6;
	localparam int SEL_W = 2;
	localparam logic [1:0] SEL_SELF = 2'h1;
	localparam logic [1:0] SEL_ALL = 2'h3;
	localparam int WEIGHT_W = 4;

	// ==========================================
	// carriers
	typedef struct packed {
		logic [7:0] eventCode;
		logic [7:0] unitMask;
		logic edgeDetect;
		logic [7:0] threshold;
	} sel_cfg_t;

	// a per-request attribute word
	typedef struct packed {
		logic valid;
		logic [3:0] lineState;
		logic fromSelf;
		logic fromPrefetcher;
	} req_t;

	typedef struct packed {
		req_t l2CodeFetch;
		req_t l2Read;
		req_t l2Write;
		req_t l2Request;
		req_t busBurstRead;
		logic l2Busy;
		logic l2Pending;
		logic freqTransition;
		logic freqOnly;
		logic thermalTrip;
		logic selfHalted;
		logic otherHalted;
		logic [3:0] l1CacheReadState;
		logic [3:0] l1CacheWriteState;
		logic [3:0] l1LockInvalidState;
		logic l1AnyRef;
		logic l1CacheableRef;
		logic l1Replace;
		logic l1ModAlloc;
		logic l1ModEvict;
		logic [3:0] l1MissCount;
		logic dtlbMiss;
		logic [3:0] prefMiss;
		logic l1PrefReq;
		logic [3:0] busReadOutL1;
		logic [3:0] busReadOutPref;
	} core_ev_t;

	typedef struct packed {
		logic cycle;
		logic blockNext;
		logic dataValid;
		logic dataValidSelf;
		logic busLock;
		logic busLockSelf;
		logic dataChunk;
	} bus_ev_t;

endpackage

// ### hw/cache_bus_event_selector.sv
// Purpose: decode event code and unit mask into a counter increment
// Assumes: event inputs come from core-clock logic; bus pins pass two flops
// Notes: counter itself lives outside; this block drives only the increment and matched
//
`timescale 1ns/10ps

// Overview of operation
// RULE1 - 28H counts L2 code fetches, state and core qualified
// RULE2 - 29H L2 reads, 2AH L2 writes, state and core qualified
// RULE3 - 2EH counts L2 requests, core, prefetch and state qualified
// RULE4 - 30H counts L2 busy-refuse cycles, 32H counts idle L2 cycles
// RULE5 - 3BH counts thermal trip cycles, or entries with edge detect
// RULE6 - 3CH mask 01H running bus cycles, 02H only while other halted
// RULE7 - 40H,41H,42H cacheable reads, writes, locked invalid reads, state qualified
// RULE8 - 43H all L1 data references, 44H only cacheable ones
// RULE9 - 45H with mask 0FH counts L1 line replacements
// RULE10 - 46H counts modified allocations, 47H modified evictions
// RULE11 - 48H adds outstanding misses; threshold one counts busy cycles
// RULE12 - 49H counts data TLB misses
// RULE13 - 4BH counts prefetch and streaming store misses by mask
// RULE14 - 4FH counts L1 prefetch requests, resubmits may recount
// RULE15 - 60H adds outstanding full-line bus reads, excluding other kinds
// RULE16 - 60H threshold one gives duration; mask bit picks prefetcher
// RULE17 - 61H bus cycles with block-next, 62H agent-qualified bus cycles with data-valid
// RULE18 - 63H bus cycles with bus lock, core qualified
// RULE19 - 64H mask 40H counts received data chunks
// RULE20 - 65H counts burst read transactions, core qualified
// RULE21 - unlisted code and mask pairs never increment
// RULE22 - weighted increment equals occurrences; threshold turns it to one
module cache_bus_event_selector
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// selection
	input wire evsel_pkg::sel_cfg_t cfg,
	// events on the core clock
	input wire evsel_pkg::core_ev_t coreEv,
	// external bus signals
	input wire evsel_pkg::bus_ev_t busPins,
	// increment to the counter
	output logic [evsel_pkg::WEIGHT_W-1:0] increment,
	output logic matched
);

	// ==========================================
	// pin synchroniser
	evsel_pkg::bus_ev_t busMeta_r;
	evsel_pkg::bus_ev_t busSync_r;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			busMeta_r <= '0;
			busSync_r <= '0;
		end
		else
		begin
			busMeta_r <= busPins;
			busSync_r <= busMeta_r;
		end
	end

	// ==========================================
	// qualification helpers
	logic [3:0] stateSel;
	logic [1:0] coreSel;
	logic prefInc;
	logic prefExc;

	assign stateSel = cfg.unitMask[evsel_pkg::STATE_LSB +: evsel_pkg::STATE_W];
	assign coreSel = cfg.unitMask[evsel_pkg::SEL_LSB +: evsel_pkg::SEL_W];
	assign prefInc = cfg.unitMask[evsel_pkg::PREF_INC_BIT];
	assign prefExc = cfg.unitMask[evsel_pkg::PREF_EXC_BIT];

	function automatic logic coreOk(input logic fromSelf, input logic [1:0] sel);
		coreOk = (sel == evsel_pkg::SEL_ALL) || (sel == evsel_pkg::SEL_SELF && fromSelf);
	endfunction

	function automatic logic reqOk(input evsel_pkg::req_t r, input logic [3:0] st, input logic [1:0] sel);
		reqOk = r.valid && ((r.lineState & st) != 4'h0) && coreOk(r.fromSelf, sel);
	endfunction

	// thermal entry edge; input is treated as same-clock logic
	logic thermalPrev_r;

	always_ff @(posedge clock)
	begin
		if (reset)
			thermalPrev_r <= 1'b0;
		else
			thermalPrev_r <= coreEv.thermalTrip;
	end

	// ==========================================
	// raw per-cycle occurrence count
	logic [evsel_pkg::WEIGHT_W-1:0] raw;
	logic hit;
	logic weighted;
	logic [3:0] busOut;

	always_comb
	begin
		raw = '0;
		hit = 1'b0;
		weighted = 1'b0;
		busOut = 4'h0;
		case (cfg.eventCode)
			// RULE1 code fetches
			evsel_pkg::EV_L2_CODE_FETCH:
			begin
				hit = 1'b1;
				raw = {3'h0, reqOk(coreEv.l2CodeFetch, stateSel, coreSel)};
			end
			// RULE2 reads
			evsel_pkg::EV_L2_READ:
			begin
				hit = 1'b1;
				raw = {3'h0, reqOk(coreEv.l2Read, stateSel, coreSel)};
			end
			// RULE2 writes
			evsel_pkg::EV_L2_WRITE:
			begin
				hit = 1'b1;
				raw = {3'h0, reqOk(coreEv.l2Write, stateSel, coreSel)};
			end
			// RULE3 prefetch filter
			evsel_pkg::EV_L2_REQUEST:
			begin
				hit = 1'b1;
				raw = {3'h0, reqOk(coreEv.l2Request, stateSel, coreSel)
					&& (coreEv.l2Request.fromPrefetcher ? !prefExc : !prefInc || prefExc)};
			end
			// RULE4 busy cycles
			evsel_pkg::EV_L2_BUSY_REFUSE:
			begin
				hit = 1'b1;
				raw = {3'h0, coreEv.l2Busy};
			end
			// RULE4 idle cycles
			evsel_pkg::EV_L2_IDLE:
			begin
				hit = 1'b1;
				raw = {3'h0, !coreEv.l2Pending};
			end
			evsel_pkg::EV_FREQ_TRANS:
			begin
				hit = (cfg.unitMask == evsel_pkg::UM_FREQ_ANY) || (cfg.unitMask == evsel_pkg::UM_FREQ_ONLY);
				raw = {3'h0, hit && coreEv.freqTransition
					&& (cfg.unitMask == evsel_pkg::UM_FREQ_ANY || coreEv.freqOnly)};
			end
			// RULE5 trip duration or entry
			evsel_pkg::EV_THERMAL_TRIP:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_THERMAL;
				raw = {3'h0, hit && coreEv.thermalTrip && (!cfg.edgeDetect || !thermalPrev_r)};
			end
			// RULE6 running bus cycles
			evsel_pkg::EV_RUNNING_BUS:
			begin
				hit = (cfg.unitMask == evsel_pkg::UM_RUNNING) || (cfg.unitMask == evsel_pkg::UM_SERIAL);
				raw = {3'h0, hit && busSync_r.cycle && !coreEv.selfHalted
					&& (cfg.unitMask == evsel_pkg::UM_RUNNING || coreEv.otherHalted)};
			end
			// RULE7 cacheable reads
			evsel_pkg::EV_L1_CACHE_READ:
			begin
				hit = 1'b1;
				raw = {3'h0, (coreEv.l1CacheReadState & stateSel) != 4'h0};
			end
			// RULE7 cacheable writes
			evsel_pkg::EV_L1_CACHE_WRITE:
			begin
				hit = 1'b1;
				raw = {3'h0, (coreEv.l1CacheWriteState & stateSel) != 4'h0};
			end
			// RULE7 locked reads
			evsel_pkg::EV_L1_LOCKED_READ:
			begin
				hit = 1'b1;
				raw = {3'h0, (coreEv.l1LockInvalidState & stateSel) != 4'h0};
			end
			// RULE8 all references
			evsel_pkg::EV_L1_ALL_REF:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_ALL_REF;
				raw = {3'h0, hit && coreEv.l1AnyRef};
			end
			// RULE8 cacheable references
			evsel_pkg::EV_L1_CACHE_REF:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_CACHE_REF;
				raw = {3'h0, hit && coreEv.l1CacheableRef};
			end
			// RULE9 replacements
			evsel_pkg::EV_L1_REPLACE:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_REPLACE;
				raw = {3'h0, hit && coreEv.l1Replace};
			end
			// RULE10 modified alloc
			evsel_pkg::EV_L1_MOD_ALLOC:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_ZERO;
				raw = {3'h0, hit && coreEv.l1ModAlloc};
			end
			// RULE10 modified evict
			evsel_pkg::EV_L1_MOD_EVICT:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_ZERO;
				raw = {3'h0, hit && coreEv.l1ModEvict};
			end
			// RULE11 outstanding misses
			evsel_pkg::EV_L1_MISS_PEND:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_ZERO;
				weighted = 1'b1;
				raw = hit ? coreEv.l1MissCount : 4'h0;
			end
			// RULE12 tlb misses
			evsel_pkg::EV_DTLB_MISS:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_ZERO;
				raw = {3'h0, hit && coreEv.dtlbMiss};
			end
			// RULE13 mask picks kind
			evsel_pkg::EV_PREF_MISS:
			begin
				hit = cfg.unitMask <= evsel_pkg::UM_STREAM;
				raw = {3'h0, hit && coreEv.prefMiss[cfg.unitMask[1:0]]};
			end
			// RULE14 prefetch requests
			evsel_pkg::EV_L1_PREFETCH_REQUEST_EVENT:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_ZERO;
				raw = {3'h0, hit && coreEv.l1PrefReq};
			end
			// RULE15 RULE16 outstanding reads
			evsel_pkg::EV_BUS_READ_OUT:
			begin
				hit = 1'b1;
				weighted = 1'b1;
				busOut = (prefExc ? 4'h0 : coreEv.busReadOutPref);
				raw = (prefInc && !prefExc) ? busOut : 4'(coreEv.busReadOutL1 + busOut);
			end
			// RULE17 block-next cycles
			evsel_pkg::EV_BUS_BLOCK:
			begin
				hit = cfg.unitMask[3:0] == 4'h0;
				raw = {3'h0, hit && busSync_r.cycle && busSync_r.blockNext};
			end
			// RULE17 data-valid cycles
			evsel_pkg::EV_BUS_DATA_VALID:
			begin
				hit = 1'b1;
				raw = {3'h0, busSync_r.cycle && busSync_r.dataValid
					&& coreOk(busSync_r.dataValidSelf, coreSel)};
			end
			// RULE18 lock cycles
			evsel_pkg::EV_BUS_LOCK:
			begin
				hit = 1'b1;
				raw = {3'h0, busSync_r.cycle && busSync_r.busLock
					&& coreOk(busSync_r.busLockSelf, coreSel)};
			end
			// RULE19 data chunks
			evsel_pkg::EV_BUS_DATA_RCV:
			begin
				hit = cfg.unitMask == evsel_pkg::UM_DATA_RCV;
				raw = {3'h0, hit && busSync_r.cycle && busSync_r.dataChunk};
			end
			// RULE20 burst reads
			evsel_pkg::EV_BUS_BURST_READ:
			begin
				hit = 1'b1;
				raw = {3'h0, coreEv.busBurstRead.valid && coreOk(coreEv.busBurstRead.fromSelf, coreSel)};
			end
			// RULE21 unlisted code
			default:
			begin
				hit = 1'b0;
				raw = '0;
			end
		endcase
	end

	// ==========================================
	// threshold and output register
	logic [evsel_pkg::WEIGHT_W-1:0] incNxt;

	always_comb
	begin
		// RULE21 no match, no count
		if (!hit)
			incNxt = '0;
		// RULE22 threshold compare
		else if (weighted && cfg.threshold != 8'h00)
			incNxt = ({4'h0, raw} >= cfg.threshold) ? 4'h1 : 4'h0;
		else
			incNxt = raw;
	end

	logic [evsel_pkg::WEIGHT_W-1:0] increment_r;
	logic matched_r;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			increment_r <= '0;
			matched_r <= 1'b0;
		end
		else
		begin
			increment_r <= incNxt;
			matched_r <= hit;
		end
	end

	assign increment = increment_r;
	assign matched = matched_r;

	// ==========================================
	// checks
	// RULE21 zero when unmatched
	AST_NOMATCH_ZERO: assert property (@(posedge clock) disable iff (reset) // RULE21
		!hit |=> increment == 4'h0)
		else $error("unmatched selection produced an increment");

	// RULE22 threshold gives at most one
	AST_THRESH_ONE: assert property (@(posedge clock) disable iff (reset) // RULE22
		(weighted && cfg.threshold != 8'h00) |=> increment <= 4'h1)
		else $error("threshold mode increment above one");

	// RULE11 weighted equals count
	AST_MISS_WEIGHT: assert property (@(posedge clock) disable iff (reset) // RULE11
		(cfg.eventCode == evsel_pkg::EV_L1_MISS_PEND && cfg.unitMask == 8'h00 && cfg.threshold == 8'h00)
		|=> increment == $past(coreEv.l1MissCount))
		else $error("miss weight not passed through");

	// RULE5 edge counts once
	AST_THERMAL_EDGE: assert property (@(posedge clock) disable iff (reset) // RULE5
		(cfg.eventCode == evsel_pkg::EV_THERMAL_TRIP && cfg.edgeDetect && thermalPrev_r)
		|=> increment == 4'h0)
		else $error("thermal trip counted twice in edge mode");

	// RULE4 idle cycle
	AST_L2_IDLE: assert property (@(posedge clock) disable iff (reset) // RULE4
		(cfg.eventCode == evsel_pkg::EV_L2_IDLE) |=> increment == {3'h0, !$past(coreEv.l2Pending)})
		else $error("idle cycle count wrong");

	// RULE17 bus block cycles follow pins after sync
	AST_BUS_BLOCK: assert property (@(posedge clock) disable iff (reset) // RULE17
		(cfg.eventCode == evsel_pkg::EV_BUS_BLOCK && cfg.unitMask == 8'h00
			&& busSync_r.cycle && busSync_r.blockNext) |=> increment == 4'h1)
		else $error("block-next cycle not counted");

	// RULE9 wrong mask
	AST_REPLACE_MASK: assert property (@(posedge clock) disable iff (reset) // RULE9
		(cfg.eventCode == evsel_pkg::EV_L1_REPLACE && cfg.unitMask != 8'h0f) |=> !matched)
		else $error("replacement matched with wrong mask");

	// RULE6 serial needs other halted
	AST_SERIAL: assert property (@(posedge clock) disable iff (reset) // RULE6
		(cfg.eventCode == evsel_pkg::EV_RUNNING_BUS && cfg.unitMask == 8'h02 && !coreEv.otherHalted)
		|=> increment == 4'h0)
		else $error("serial cycle counted while other core runs");

endmodule

// ### tb/cache_bus_event_selector_tb.sv
// Purpose: self-checking bench for the cache and bus event selector
// Assumes: outputs follow cfg and core events by one edge, bus pins by three
// Notes: bus-read weights stay below 8 so their sum fits the increment width
`timescale 1ns/10ps

module cache_bus_event_selector_tb;
	// ==========================================
	// signals
	logic clock;
	logic reset;
	evsel_pkg::sel_cfg_t cfg;
	evsel_pkg::core_ev_t coreEv;
	evsel_pkg::bus_ev_t busPins;
	logic [evsel_pkg::WEIGHT_W-1:0] increment;
	logic matched;
	evsel_pkg::bus_ev_t busH1;
	evsel_pkg::bus_ev_t busH2;
	logic prevTh;
	int n_fail;
	int comparisons;
	logic [15:0] badPairs [12] = '{16'h450e, 16'h6400, 16'h3c03, 16'h6101, 16'h4302, 16'h3a01,
		16'h4b04, 16'h2b00, 16'h3100, 16'h4a00, 16'h6600, 16'h0000};

	cache_bus_event_selector dut_u
	(
		.clock(clock),
		.reset(reset),
		.cfg(cfg),
		.coreEv(coreEv),
		.busPins(busPins),
		.increment(increment),
		.matched(matched)
	);

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ==========================================
	// expectation
	function automatic logic reqHit(input evsel_pkg::req_t r, input logic [7:0] m);
		return r.valid && (r.lineState & m[3:0]) != 4'h0 && (m[7:6] == 2'h3 || (m[7:6] == 2'h1 && r.fromSelf));
	endfunction

	function automatic logic agent(input logic [1:0] s, input logic any, input logic self);
		return (s == 2'h3) ? any : (s == 2'h1 && any && self);
	endfunction

	// threshold turns a weight into a single count
	function automatic logic [3:0] weigh(input logic [3:0] raw, input logic [7:0] thr);
		return (thr == 8'h00) ? raw : {3'h0, ({4'h0, raw} >= thr)};
	endfunction

	function automatic logic listed(input logic [7:0] c, input logic [7:0] m);
		case (c)
			8'h28, 8'h29, 8'h2a, 8'h2e, 8'h30, 8'h32, 8'h40, 8'h41, 8'h42, 8'h60, 8'h62, 8'h63, 8'h65: return 1'b1;
			8'h3a: return m == 8'h00 || m == 8'h10;
			8'h3b: return m == 8'hc0;
			8'h3c: return m == 8'h01 || m == 8'h02;
			8'h43: return m == 8'h01;
			8'h44: return m == 8'h02;
			8'h45: return m == 8'h0f;
			8'h46, 8'h47, 8'h48, 8'h49, 8'h4f: return m == 8'h00;
			8'h4b: return m <= 8'h03;
			8'h61: return m[3:0] == 4'h0;
			8'h64: return m == 8'h40;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [4:0] expectOut(input evsel_pkg::sel_cfg_t c, input evsel_pkg::core_ev_t e,
		input evsel_pkg::bus_ev_t b, input logic pt);
		logic [7:0] m;
		logic hit;
		logic [3:0] w;
		m = c.unitMask;
		hit = 1'b0;
		case (c.eventCode)
			8'h28: hit = reqHit(e.l2CodeFetch, m);
			8'h29: hit = reqHit(e.l2Read, m);
			8'h2a: hit = reqHit(e.l2Write, m);
			8'h2e: hit = reqHit(e.l2Request, m) && (m[5] ? !e.l2Request.fromPrefetcher
				: (!m[4] || e.l2Request.fromPrefetcher));
			8'h30: hit = e.l2Busy;
			8'h32: hit = !e.l2Pending;
			8'h3a: hit = e.freqTransition && (m == 8'h00 || e.freqOnly);
			8'h3b: hit = e.thermalTrip && !(c.edgeDetect && pt);
			8'h3c: hit = b.cycle && !e.selfHalted && (m == 8'h01 || e.otherHalted);
			8'h40: hit = (e.l1CacheReadState & m[3:0]) != 4'h0;
			8'h41: hit = (e.l1CacheWriteState & m[3:0]) != 4'h0;
			8'h42: hit = (e.l1LockInvalidState & m[3:0]) != 4'h0;
			8'h43: hit = e.l1AnyRef;
			8'h44: hit = e.l1CacheableRef;
			8'h45: hit = e.l1Replace;
			8'h46: hit = e.l1ModAlloc;
			8'h47: hit = e.l1ModEvict;
			8'h49: hit = e.dtlbMiss;
			8'h4b: hit = e.prefMiss[m[1:0]];
			8'h4f: hit = e.l1PrefReq;
			8'h61: hit = b.cycle && b.blockNext;
			8'h62: hit = b.cycle && agent(m[7:6], b.dataValid, b.dataValidSelf);
			8'h63: hit = b.cycle && agent(m[7:6], b.busLock, b.busLockSelf);
			8'h64: hit = b.cycle && b.dataChunk;
			8'h65: hit = reqHit(e.busBurstRead, m);
			default: hit = 1'b0;
		endcase
		w = {3'h0, hit};
		if (c.eventCode == 8'h48)
			w = weigh(e.l1MissCount, c.threshold);
		if (c.eventCode == 8'h60)
			w = weigh(m[5] ? e.busReadOutL1 : (m[4] ? e.busReadOutPref : e.busReadOutL1 + e.busReadOutPref),
				c.threshold);
		return listed(c.eventCode, m) ? {1'b1, w} : 5'h00;
	endfunction

	// ==========================================
	// checking and closing
	task automatic check(input logic [4:0] seen, input logic [4:0] want);
		comparisons++;
		if (seen !== want)
		begin
			n_fail++;
			$display("CHECK FAILED matched_increment expected %h seen %h cfg %h at %0t", want, seen, cfg, $time);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================
	// stimulus
	task automatic tick(input logic [7:0] code, input logic [7:0] am, input logic [7:0] om, input logic ed,
		input logic [7:0] thr, input logic cycR, input logic rst);
		logic [4:0] want;
		logic [95:0] rnd;
		evsel_pkg::core_ev_t ev;
		evsel_pkg::bus_ev_t bus;
		@(posedge clock);
		want = reset ? 5'h00 : expectOut(cfg, coreEv, busH2, prevTh);
		busH2 = busH1;
		busH1 = busPins;
		prevTh = coreEv.thermalTrip;
		rnd = {$urandom(), $urandom(), $urandom()};
		ev = rnd[$bits(evsel_pkg::core_ev_t)-1:0];
		bus = rnd[95:89];
		ev.busReadOutL1[3] = 1'b0;
		ev.busReadOutPref[3] = 1'b0;
		ev.busBurstRead.lineState[0] = 1'b1;
		if (rst)
			ev.thermalTrip = 1'b0;
		if (!cycR)
			bus.cycle = 1'b1;
		if (rst)
			bus = '0;
		reset <= rst;
		cfg <= '{code, (8'($urandom()) & am) | om, ed, thr};
		coreEv <= ev;
		busPins <= bus;
		#1;
		check({matched, increment}, want);
	endtask

	task automatic run(input logic [7:0] code, input logic [7:0] am, input logic [7:0] om, input logic ed,
		input logic [7:0] thr, input logic cycR, input logic rst, input int n = 40);
		repeat (n) tick(code, am, om, ed, thr, cycR, rst);
	endtask

	initial
	begin
		#400000;
		n_fail++;
		conclude();
	end

	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'hab2c70e6));
		reset = 1'b1;
		cfg = '0;
		coreEv = '0;
		busPins = '0;
		busH1 = '0;
		busH2 = '0;
		prevTh = 1'b0;
		n_fail = 0;
		comparisons = 0;
		run(8'h48, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1, 11);
		run(8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 4);
		run(8'h28, 8'hcf, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // code fetches
		run(8'h29, 8'hcf, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // reads
		run(8'h2a, 8'hcf, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // writes
		run(8'h2e, 8'hff, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 80); // all requests
		run(8'h30, 8'h00, 8'hcf, 1'b0, 8'h00, 1'b0, 1'b0); // busy cycles
		run(8'h32, 8'h00, 8'hcf, 1'b0, 8'h00, 1'b0, 1'b0); // idle cycles
		run(8'h3a, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		run(8'h3a, 8'h00, 8'h10, 1'b0, 8'h00, 1'b0, 1'b0);
		run(8'h3b, 8'h00, 8'hc0, 1'b0, 8'h00, 1'b0, 1'b0); // trip duration
		run(8'h3b, 8'h00, 8'hc0, 1'b1, 8'h00, 1'b0, 1'b0); // trip entries
		run(8'h3c, 8'h00, 8'h01, 1'b0, 8'h00, 1'b1, 1'b0); // running cycles
		run(8'h3c, 8'h00, 8'h02, 1'b0, 8'h00, 1'b1, 1'b0); // other halted
		run(8'h40, 8'h0f, 8'hc0, 1'b0, 8'h00, 1'b0, 1'b0); // cacheable reads
		run(8'h41, 8'h0f, 8'hc0, 1'b0, 8'h00, 1'b0, 1'b0); // cacheable writes
		run(8'h42, 8'h0f, 8'hc0, 1'b0, 8'h00, 1'b0, 1'b0); // locked reads
		run(8'h43, 8'h00, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0); // all references
		run(8'h44, 8'h00, 8'h02, 1'b0, 8'h00, 1'b0, 1'b0); // cacheable references
		run(8'h45, 8'h00, 8'h0f, 1'b0, 8'h00, 1'b0, 1'b0); // line replacements
		run(8'h46, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // modified allocations
		run(8'h47, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // modified evictions
		run(8'h48, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // weighted misses
		run(8'h48, 8'h00, 8'h00, 1'b0, 8'h01, 1'b0, 1'b0); // duration
		run(8'h48, 8'h00, 8'h00, 1'b0, 8'h05, 1'b0, 1'b0); // threshold
		run(8'h49, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // translation misses
		for (int k = 0; k < 4; k++)
			run(8'h4b, 8'h00, 8'(k), 1'b0, 8'h00, 1'b0, 1'b0); // miss kinds
		run(8'h4f, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0); // prefetch requests
		run(8'h60, 8'h30, 8'hcf, 1'b0, 8'h00, 1'b0, 1'b0, 80); // weighted reads
		run(8'h60, 8'h30, 8'hcf, 1'b0, 8'h01, 1'b0, 1'b0); // duration
		run(8'h60, 8'h30, 8'hcf, 1'b0, 8'h03, 1'b0, 1'b0); // threshold
		// bus-cycle strobe left random so counts outside bus cycles are caught
		run(8'h61, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0); // block cycles
		run(8'h62, 8'h00, 8'hcf, 1'b0, 8'h00, 1'b1, 1'b0); // data valid
		run(8'h63, 8'h00, 8'hcf, 1'b0, 8'h00, 1'b1, 1'b0); // lock cycles
		run(8'h64, 8'h00, 8'h40, 1'b0, 8'h00, 1'b1, 1'b0); // data chunks
		run(8'h65, 8'h00, 8'hcf, 1'b0, 8'h00, 1'b0, 1'b0); // burst reads
		foreach (badPairs[k])
			run(badPairs[k][15:8], 8'h00, badPairs[k][7:0], 1'b0, 8'h00, 1'b0, 1'b0, 10); // bad pairs
		repeat (8)
			run(8'h80 | 8'($urandom()), 8'hff, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 10); // unlisted codes
		// reset in mid-run must clear the weighted output at once
		run(8'h48, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1, 4);
		run(8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 4);
		run(8'h48, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 10); // after reset
		conclude();
	end
endmodule
